// ==== rtl/switch_monitor_pkg.sv ====
// switch monitor command decoder: shared constants and types
// assumes a 16-bit serial command word, msb first, framed by an active-low select
package switch_monitor_pkg;

    // ****************************************
    // command word layout
    // ****************************************
    localparam int WORD_BITS      = 16;
    localparam int OPCODE_MSB     = 15;
    localparam int OPCODE_LSB     = 12;
    localparam int MODE_MSB       = 11;
    localparam int MODE_LSB       = 10;
    localparam int OFF_MSB        = 9;
    localparam int OFF_LSB        = 7;
    localparam int WAKE_MSB       = 5;
    localparam int WAKE_LSB       = 4;
    localparam int POL_MSB        = 3;
    localparam int POL_LSB        = 0;
    localparam int PAYLOAD_BITS   = 12;

    localparam logic [3:0] OP_SLEEP    = 4'h0;
    localparam logic [3:0] OP_RUN      = 4'h1;
    localparam logic [3:0] OP_TRISTATE = 4'h3;
    localparam logic [3:0] OP_METALLIC = 4'h5;

    localparam logic [11:0] ENABLE_RESET = 12'h000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ           = 50_000_000;
    localparam int OFF_DETECT_US    = 4800;
    localparam int WAKE_DETECT_US   = 2800;
    localparam int OFF_DETECT_CYC   = OFF_DETECT_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_DETECT_CYC  = WAKE_DETECT_US * (CLK_HZ / 1_000_000);
    localparam int ON_TIME_US       = 5100;
    localparam int ON_TIME_CYC      = ON_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_POLL,
        MODE_POLL_WAKE
    } op_mode_t;

    typedef enum logic [1:0] {
        POLL_IDLE,
        POLL_ON,
        POLL_OFF
    } poll_state_t;

    // off-time multiplier per code
    function automatic logic [5:0] off_mult(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h05;
        case (code)
            3'h0: m = 6'h05;
            3'h1: m = 6'h09;
            3'h2: m = 6'h11;
            3'h3: m = 6'h19;
            3'h4: m = 6'h21;
            3'h5: m = 6'h29;
            3'h6: m = 6'h31;
            default: m = 6'h39;
        endcase
        return m;
    endfunction : off_mult

    // wake multiplier per code
    function automatic logic [9:0] wake_mult(input logic [1:0] code);
        logic [9:0] m;
        m = 10'h201;
        case (code)
            2'h0: m = 10'h201;
            2'h1: m = 10'h101;
            2'h2: m = 10'h081;
            default: m = 10'h041;
        endcase
        return m;
    endfunction : wake_mult

endpackage : switch_monitor_pkg

// ==== rtl/switch_monitor_command_decoder.sv ====
// switch monitor command decoder: serial slave, command decode, poll and wake timers
// assumes spi mode 0 from the host; sck_link is a clock port active only inside frames
`timescale 1ns/1ps
module switch_monitor_command_decoder
    import switch_monitor_pkg::*;
#(
    parameter int OFF_DETECT_CYCLES  = OFF_DETECT_CYC,
    parameter int WAKE_DETECT_CYCLES = WAKE_DETECT_CYC,
    parameter int ON_TIME_CYCLES     = ON_TIME_CYC
) (
    // system
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // serial link
    input  wire logic        sck_link,
    input  wire logic        cs_b,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // switch status from comparators
    input  wire logic [11:0] switch_status,
    input  wire logic        master_strap,
    // control outputs
    output op_mode_t         operating_mode,
    output logic [11:0]      input_enable,
    output logic [11:0]      wetting_pulse_en,
    output logic [3:0]       programmable_polarity,
    output logic             inputs_powered,
    output logic             test_mode,
    output logic             int_b
);

    // elaboration check: every timer needs at least one cycle per period
    if (OFF_DETECT_CYCLES < 1 || WAKE_DETECT_CYCLES < 1
        || ON_TIME_CYCLES < 1) begin : g_bad_counts
        $error("timer counts must be at least one");
    end

    // ****************************************
    // link domain: shift in, shift out
    // ****************************************
    logic [15:0] shift_in;
    logic [4:0]  bit_count;
    logic [15:0] shift_out;
    logic [15:0] word_link;
    logic        word_toggle;
    logic [15:0] status_sys;

    always_ff @(posedge sck_link or posedge cs_b) begin
        if (cs_b) begin
            bit_count <= 5'h00;
        end else if (bit_count != 5'h10) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    always_ff @(posedge sck_link or negedge rst_b) begin
        if (!rst_b) begin
            shift_in    <= 16'h0000;
            word_link   <= 16'h0000;
            word_toggle <= 1'b0;
        end else if (!cs_b) begin
            shift_in <= {shift_in[14:0], mosi};
            if (bit_count == 5'h0F) begin
                word_link   <= {shift_in[14:0], mosi};
                word_toggle <= ~word_toggle;
            end
        end
    end

    // status word is frozen in sys domain during a frame; bit 15 goes out directly,
    // the remaining bits load on the first falling edge and shift on the later ones
    always_ff @(negedge sck_link or posedge cs_b) begin
        if (cs_b) begin
            shift_out <= 16'h0000;
        end else if (bit_count == 5'h01) begin
            shift_out <= {status_sys[14:0], 1'b0};
        end else begin
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end

    assign miso    = (bit_count == 5'h00) ? status_sys[15] : shift_out[15];
    assign miso_oe = ~cs_b;

    // ****************************************
    // crossing into the system domain
    // ****************************************
    logic [2:0] tog_sync;
    logic       word_valid;
    logic [15:0] cmd;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], word_toggle};
        end
    end

    assign word_valid = tog_sync[2] ^ tog_sync[1];

    // word_link is held stable for 16 link clocks after the toggle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= 16'h0000;
        end else if (word_valid) begin
            cmd <= word_link;
        end
    end

    logic       cmd_go;
    logic [3:0] opcode;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_go <= 1'b0;
        end else begin
            cmd_go <= word_valid;
        end
    end

    assign opcode = cmd[OPCODE_MSB:OPCODE_LSB];

    // ****************************************
    // command decode
    // ****************************************
    logic [2:0] off_time_select;
    logic [1:0] wake_time_select;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            operating_mode <= MODE_SLEEP;
            test_mode      <= 1'b0;
        end else if (cmd_go) begin
            if (cmd[OPCODE_MSB]) begin
                test_mode <= 1'b1;
            end else if (opcode == OP_SLEEP) begin
                operating_mode <= MODE_SLEEP;
                test_mode      <= 1'b0;
            end else if (opcode == OP_RUN) begin
                test_mode <= 1'b0;
                case (cmd[MODE_MSB:MODE_LSB])
                    2'h1: operating_mode <= MODE_NORMAL;
                    2'h2: operating_mode <= MODE_POLL;
                    2'h3: operating_mode <= MODE_POLL_WAKE;
                    default: operating_mode <= operating_mode;
                endcase
            end else if (opcode == OP_TRISTATE || opcode == OP_METALLIC) begin
                test_mode <= 1'b0;
                if (operating_mode == MODE_SLEEP)
                    operating_mode <= MODE_NORMAL;
            end
        end
    end

    // run register fields; values are zero from reset until the host writes them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            off_time_select       <= 3'h0;
            wake_time_select      <= 2'h0;
            programmable_polarity <= 4'h0;
        end else if (cmd_go && opcode == OP_RUN && !cmd[OPCODE_MSB]) begin
            off_time_select       <= cmd[OFF_MSB:OFF_LSB];
            wake_time_select      <= cmd[WAKE_MSB:WAKE_LSB];
            programmable_polarity <= cmd[POL_MSB:POL_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            input_enable <= ENABLE_RESET;
        end else if (cmd_go && opcode == OP_TRISTATE) begin
            input_enable <= cmd[PAYLOAD_BITS-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wetting_pulse_en <= 12'h000;
        end else if (cmd_go && opcode == OP_METALLIC) begin
            wetting_pulse_en <= cmd[PAYLOAD_BITS-1:0];
        end
    end

    // ****************************************
    // polling and wake timers
    // ****************************************
    logic        polling;
    poll_state_t poll_state;
    logic [31:0] poll_count;
    logic [31:0] wake_count;
    logic [31:0] off_limit;
    logic [31:0] wake_limit;

    assign polling    = (operating_mode == MODE_POLL) || (operating_mode == MODE_POLL_WAKE);
    assign off_limit  = 32'(off_mult(off_time_select)) * 32'(OFF_DETECT_CYCLES);
    assign wake_limit = 32'(wake_mult(wake_time_select)) * 32'(WAKE_DETECT_CYCLES);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            poll_state <= POLL_IDLE;
            poll_count <= 32'h0;
        end else if (!polling) begin
            poll_state <= POLL_IDLE;
            poll_count <= 32'h0;
        end else begin
            case (poll_state)
                POLL_IDLE: begin
                    poll_state <= POLL_ON;
                    poll_count <= 32'h0;
                end
                POLL_ON: begin
                    if (poll_count >= 32'(ON_TIME_CYCLES - 1)) begin
                        poll_state <= POLL_OFF;
                        poll_count <= 32'h0;
                    end else begin
                        poll_count <= poll_count + 32'h1;
                    end
                end
                default: begin
                    if (poll_count >= off_limit - 32'h1) begin
                        poll_state <= POLL_ON;
                        poll_count <= 32'h0;
                    end else begin
                        poll_count <= poll_count + 32'h1;
                    end
                end
            endcase
        end
    end

    // input blocks off in sleep and during polling off-time; comparators stay wired
    assign inputs_powered = (operating_mode != MODE_SLEEP)
                            && (poll_state != POLL_OFF);

    logic wake_pulse;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_count <= 32'h0;
            wake_pulse <= 1'b0;
        end else if (operating_mode != MODE_POLL_WAKE) begin
            wake_count <= 32'h0;
            wake_pulse <= 1'b0;
        end else if (wake_count >= wake_limit - 32'h1) begin
            wake_count <= 32'h0;
            wake_pulse <= 1'b1;
        end else begin
            wake_count <= wake_count + 32'h1;
            wake_pulse <= 1'b0;
        end
    end

    // gated by the mode so a mode change in the pulse cycle raises no stray interrupt
    assign int_b = ~(wake_pulse && (operating_mode == MODE_POLL_WAKE));

    // ****************************************
    // pin inputs into the system domain
    // ****************************************
    logic [11:0] switch_meta;
    logic [11:0] switch_sync;
    logic        strap_meta;
    logic        strap_sync;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            switch_meta <= 12'h000;
            switch_sync <= 12'h000;
            strap_meta  <= 1'b0;
            strap_sync  <= 1'b0;
        end else begin
            switch_meta <= switch_status;
            switch_sync <= switch_meta;
            strap_meta  <= master_strap;
            strap_sync  <= strap_meta;
        end
    end

    // ****************************************
    // status word, settled from the previous command
    // ****************************************
    logic [1:0] mode_code;
    always_comb begin
        case (operating_mode)
            MODE_NORMAL:    mode_code = 2'h1;
            MODE_POLL:      mode_code = 2'h2;
            MODE_POLL_WAKE: mode_code = 2'h3;
            default:        mode_code = 2'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_sys <= 16'h0000;
        end else if (cs_b) begin
            status_sys <= {mode_code, strap_sync, wake_pulse,
                           switch_sync & input_enable};
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_sleep_cmd: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h0 |=> operating_mode == MODE_SLEEP)
        else $error("sleep command did not enter sleep");
    a_reset_sleep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> operating_mode == MODE_SLEEP)
        else $error("not asleep after reset");
    a_wake_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(operating_mode) == MODE_SLEEP && operating_mode != MODE_SLEEP
        |-> $past(cmd_go) && !$past(cmd[15]))
        else $error("left sleep without a command");
    a_run_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h1 && cmd[11:10] == 2'h2 |=> operating_mode == MODE_POLL)
        else $error("run did not select polling");
    a_run_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h1 && cmd[11:10] == 2'h0 |=> $stable(operating_mode))
        else $error("undefined mode changed mode");
    a_tri_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h3 && operating_mode != MODE_SLEEP |=> $stable(operating_mode))
        else $error("tri-state changed mode");
    a_tri_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h3 |=> input_enable == $past(cmd[11:0]))
        else $error("enables not loaded");
    a_nop_ops: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && (cmd[15:12] == 4'h2 || cmd[15:12] == 4'h4 || cmd[15:12] == 4'h6
        || cmd[15:12] == 4'h7) |=> $stable(operating_mode) && $stable(input_enable)
        && $stable(wetting_pulse_en))
        else $error("non-functional opcode acted");
    a_test_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15] |=> $stable(operating_mode) && $stable(input_enable))
        else $error("test word decoded");
    a_wake_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !int_b |-> operating_mode == MODE_POLL_WAKE)
        else $error("wake interrupt outside wake mode");
    a_off_dark: assert property (@(posedge clk_sys) disable iff (!rst_b)
        poll_state == POLL_OFF |-> !inputs_powered && $past(polling))
        else $error("inputs powered during off-time");
    a_metal_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h5 |=> wetting_pulse_en == $past(cmd[11:0]))
        else $error("wetting enables not loaded");
    a_sleep_dark: assert property (@(posedge clk_sys) disable iff (!rst_b)
        operating_mode == MODE_SLEEP |-> !inputs_powered)
        else $error("inputs powered in sleep");

    c_run: cover property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_go && cmd[15:12] == 4'h1);
    c_poll_off: cover property (@(posedge clk_sys) disable iff (!rst_b)
        poll_state == POLL_OFF);
    c_wake: cover property (@(posedge clk_sys) disable iff (!rst_b) !int_b);
    c_sleep_back: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $past(operating_mode) != MODE_SLEEP && operating_mode == MODE_SLEEP);

endmodule : switch_monitor_command_decoder

// ==== tb/host_spi_model.sv ====
// host side serial master model: frames one command word and captures the status word
// assumes mode 0 framing; the link clock stands still outside frames
`timescale 1ns/1ps
module host_spi_model (
    // serial link
    output logic      sck_link,
    output logic      cs_b,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sck_link = 1'b0;
        cs_b     = 1'b1;
        mosi     = 1'b0;
    end

    // shifts nbits of word msb first at a 15 ns link period; fewer than sixteen is a short frame
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] resp);
        resp = 16'h0000;
        cs_b = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            mosi = word[i];
            #7.5;
            sck_link = 1'b1;
            resp[i] = miso;
            #7.5;
            sck_link = 1'b0;
        end
        #7.5;
        cs_b = 1'b1;
        // a released data line shows the opposite of its last bit
        mosi = ~mosi;
    endtask : xfer
endmodule : host_spi_model

// ==== tb/switch_monitor_command_decoder_tb.sv ====
// self-checking bench for the switch monitor command decoder
// assumes host_spi_model as the host and shortened detect periods
`timescale 1ns/1ps
module switch_monitor_command_decoder_tb;
    import switch_monitor_pkg::*;

    localparam int OFF_DET  = 4;
    localparam int WAKE_DET = 3;

    logic        clk_sys;
    logic        rst_b;
    logic        sck_link;
    logic        cs_b;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [11:0] switch_status;
    logic        master_strap;
    op_mode_t    operating_mode;
    logic [11:0] input_enable;
    logic [11:0] wetting_pulse_en;
    logic [3:0]  programmable_polarity;
    logic        inputs_powered;
    logic        test_mode;
    logic        int_b;
    logic [15:0] resp;
    logic [15:0] md;
    int          n_errors;
    int          num_checks;
    int          cycles;

    assign md = 16'(operating_mode);

    switch_monitor_command_decoder #(
        .OFF_DETECT_CYCLES (OFF_DET),
        .WAKE_DETECT_CYCLES(WAKE_DET),
        .ON_TIME_CYCLES    (2)
    ) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .sck_link(sck_link), .cs_b(cs_b), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .switch_status(switch_status),
        .master_strap(master_strap), .operating_mode(operating_mode),
        .input_enable(input_enable), .wetting_pulse_en(wetting_pulse_en),
        .programmable_polarity(programmable_polarity), .inputs_powered(inputs_powered),
        .test_mode(test_mode), .int_b(int_b)
    );

    host_spi_model host (
        .sck_link(sck_link), .cs_b(cs_b), .mosi(mosi), .miso(miso)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // durations may land one cycle either way of the ideal count
    task automatic chk_cnt(input string what, input int exp, input int got);
        num_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            n_errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic send(input logic [15:0] word, input int nbits);
        @(negedge clk_sys);
        host.xfer(word, nbits, resp);
        repeat (8) @(posedge clk_sys);
    endtask : send

    function automatic logic pick(input bit use_int);
        return use_int ? int_b : inputs_powered;
    endfunction : pick

    // low length of the powered flag, or the period of the interrupt pulses
    task automatic measure(input bit use_int, output int n);
        int g;
        g = 0;
        while (pick(use_int) !== 1'b1 && g < 4000) begin @(negedge clk_sys); g++; end
        while (pick(use_int) !== 1'b0 && g < 8000) begin @(negedge clk_sys); g++; end
        n = 0;
        do begin @(negedge clk_sys); n++; end while (pick(use_int) === 1'b0 && n < 4000);
        if (use_int)
            while (pick(use_int) !== 1'b0 && n < 4000) begin @(negedge clk_sys); n++; end
    endtask : measure

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_state;
        chk("mode", 16'(MODE_SLEEP), md);
        chk("enable", 16'h0000, 16'(input_enable));
        chk("powered", 16'h0000, 16'(inputs_powered));
        chk("int_b", 16'h0001, 16'(int_b));
    endtask : t_reset_state

    task automatic t_wake_and_status;
        send(16'h3A5C, 16);
        chk("resp_mode", 16'h0000, 16'(resp[15:14]));
        chk("mode", 16'(MODE_NORMAL), md);
        chk("enable", 16'h0A5C, 16'(input_enable));
        send(16'h5123, 16);
        chk("wetting", 16'h0123, 16'(wetting_pulse_en));
        chk("resp_word", 16'h6A0C, resp);
        chk("miso_oe", 16'h0000, 16'(miso_oe));
    endtask : t_wake_and_status

    task automatic t_run_modes;
        logic [1:0] prev;
        for (int m = 1; m < 4; m++) begin
            prev = operating_mode;
            send({4'h1, 2'(m), 3'h2, 1'b1, 2'h1, 4'(4'h9 ^ m)}, 16);
            chk("mode", 16'(m), md);
            chk("polarity", 16'(4'h9 ^ m), 16'(programmable_polarity));
            chk("resp_mode", 16'(prev), 16'(resp[15:14]));
        end
        send(16'h1006, 16);
        chk("mode", 16'(MODE_POLL_WAKE), md);
        chk("polarity", 16'h0006, 16'(programmable_polarity));
    endtask : t_run_modes

    task automatic t_mode_kept;
        send(16'h1800, 16);
        send(16'h3FFF, 16);
        chk("mode", 16'(MODE_POLL), md);
        chk("enable", 16'h0FFF, 16'(input_enable));
        send(16'h5000, 16);
        chk("mode", 16'(MODE_POLL), md);
        chk("wetting", 16'h0000, 16'(wetting_pulse_en));
    endtask : t_mode_kept

    task automatic t_ignored_words;
        logic [3:0] ops [4];
        ops = '{4'h2, 4'h4, 4'h6, 4'h7};
        foreach (ops[i]) begin
            send({ops[i], 12'h000}, 16);
            chk("mode", 16'(MODE_POLL), md);
            chk("enable", 16'h0FFF, 16'(input_enable));
        end
        send(16'hB000, 16);
        chk("test_mode", 16'h0001, 16'(test_mode));
        chk("enable", 16'h0FFF, 16'(input_enable));
        send(16'h0000, 15);
        chk("mode", 16'(MODE_POLL), md);
        send(16'h3FFF, 16);
        chk("test_mode", 16'h0000, 16'(test_mode));
    endtask : t_ignored_words

    task automatic t_off_time;
        int offm [8] = '{5, 9, 17, 25, 33, 41, 49, 57};
        int n;
        for (int c = 0; c < 8; c++) begin
            send({4'h1, 2'b10, 3'(c), 1'b0, 2'b00, 4'h0}, 16);
            measure(1'b0, n);
            chk_cnt("off_time", offm[c] * OFF_DET, n);
        end
    endtask : t_off_time

    task automatic t_wake_timer;
        int wakm [4] = '{513, 257, 129, 65};
        int n;
        for (int w = 0; w < 4; w++) begin
            send({4'h1, 2'b11, 3'h0, 1'b0, 2'(w), 4'h0}, 16);
            measure(1'b1, n);
            chk_cnt("wake_interval", wakm[w] * WAKE_DET, n);
        end
        send(16'h1800, 16);
        n = 0;
        repeat (2000) begin @(negedge clk_sys); if (int_b === 1'b0) n++; end
        chk("poll_int_pulses", 16'h0000, 16'(n));
    endtask : t_wake_timer

    task automatic t_sleep_and_reset;
        send(16'h0FFF, 16);
        chk("mode", 16'(MODE_SLEEP), md);
        chk("powered", 16'h0000, 16'(inputs_powered));
        send(16'h1400, 16);
        chk("mode", 16'(MODE_NORMAL), md);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("mode", 16'(MODE_SLEEP), md);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("mode", 16'(MODE_SLEEP), md);
        chk("enable", 16'h0000, 16'(input_enable));
    endtask : t_sleep_and_reset

    initial begin
        rst_b         <= 1'b0;
        switch_status <= 12'hF0F;
        master_strap  <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset_state();
        t_wake_and_status();
        t_run_modes();
        t_mode_kept();
        t_ignored_words();
        t_off_time();
        t_wake_timer();
        t_sleep_and_reset();
        give_verdict();
    end
endmodule : switch_monitor_command_decoder_tb
